// file: pkg/scst_defines.svh
// constants of the configurable serial channel
`ifndef SCST_DEFINES_SVH
`define SCST_DEFINES_SVH
// ==========================================
// clock and baud figures
`define SCST_CLK_HZ 200000000
`define SCST_BAUD_19200 19200
`define SCST_BAUD_9600 9600
`define SCST_BAUD_4800 4800
`define SCST_BAUD_2400 2400
`define SCST_BAUD_1200 1200
`define SCST_BAUD_600 600
`define SCST_BAUD_300 300
// ==========================================
// receive buffer and flow thresholds
`define SCST_BUF_DEPTH 96
`define SCST_HI_PCT 50
`define SCST_LO_PCT 35
`define SCST_PAUSE_CHAR 8'h13
`define SCST_RESUME_CHAR 8'h11
// ==========================================
// setup update enables, one bit per setting
`define SCST_UPD_MODE 0
`define SCST_UPD_BAUD 1
`define SCST_UPD_LONG 2
`define SCST_UPD_PAR 3
`define SCST_UPD_STOP 4
// ==========================================
// reset values of the settings
`define SCST_RST_MODE scst_pkg::SCST_HS_CHAR
`define SCST_RST_BAUD scst_pkg::SCST_B9600
`define SCST_RST_CHAR8 1'b1
`define SCST_RST_PAR scst_pkg::SCST_PAR_NONE
`define SCST_RST_TWO_STOP 1'b1
`endif

// file: pkg/scst_pkg.sv
// types of the configurable serial channel
package scst_pkg;
  typedef enum logic [2:0] {SCST_B19200, SCST_B9600, SCST_B4800, SCST_B2400,
                            SCST_B1200, SCST_B600, SCST_B300} scst_baud_type;
  typedef enum logic [1:0] {SCST_PAR_NONE, SCST_PAR_EVEN, SCST_PAR_ODD} scst_par_type;
  typedef enum logic {SCST_HS_CHAR, SCST_HS_FLOW} scst_hs_type;
  typedef enum logic [2:0] {SCST_IDLE, SCST_START, SCST_DATA, SCST_PARB, SCST_STOP} scst_state_type;
endpackage

// file: verilog/scst_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module scst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [LW-1:0] cnt_q;
  logic push, pop;

  assign in_ready_o = (cnt_q != LW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign level_o = cnt_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + LW'(push) - LW'(pop);
    end
  end

  AST_FIFO_NO_OVERFILL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cnt_q == LW'(DEPTH) |=> cnt_q <= LW'(DEPTH)) else $error("fifo overfilled");
endmodule // scst_fifo
`default_nettype wire

// file: verilog/scst_serial_channel.sv
// configurable asynchronous serial channel with role, route and flow control
`timescale 1ns/100ps
`default_nettype none
`include "scst_defines.svh"
module scst_serial_channel #(
  parameter int CLK_HZ = `SCST_CLK_HZ,
  parameter int BUF_DEPTH = `SCST_BUF_DEPTH
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // setup command: per-setting update enables
  input wire logic cfg_wr_i,
  input wire logic [4:0] cfg_upd_i,
  input wire scst_pkg::scst_hs_type cfg_mode_i,
  input wire scst_pkg::scst_baud_type cfg_baud_i,
  input wire logic cfg_char8_i,
  input wire scst_pkg::scst_par_type cfg_par_i,
  input wire logic cfg_two_stop_i,
  // board switches
  input wire logic role_modem_i,
  input wire logic [2:0] rts_sel_i,
  // user transmit
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  // user receive
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  // status
  output logic err_parity_o,
  output logic err_frame_o,
  output logic err_overrun_o,
  input wire logic err_clr_i,
  // cable lines
  input wire logic txd_pin_i,
  output logic txd_pin_o,
  output logic txd_pin_oe_o,
  input wire logic rxd_pin_i,
  output logic rxd_pin_o,
  output logic rxd_pin_oe_o,
  input wire logic cts_pin_i,
  output logic cts_pin_o,
  output logic cts_pin_oe_o,
  input wire logic dsr_pin_i,
  output logic dsr_pin_o,
  output logic dsr_pin_oe_o,
  input wire logic dtr_pin_i,
  output logic dtr_pin_o,
  output logic dtr_pin_oe_o,
  input wire logic [2:0] rts_pin_i,
  output logic [2:0] rts_pin_o,
  output logic [2:0] rts_pin_oe_o
);
  import scst_pkg::*;
  localparam int LW = $clog2(BUF_DEPTH+1);
  localparam logic [LW-1:0] HI_LVL = LW'(BUF_DEPTH * `SCST_HI_PCT / 100);
  localparam logic [LW-1:0] LO_LVL = LW'(BUF_DEPTH * `SCST_LO_PCT / 100);

  // ==========================================
  // settings
  scst_hs_type mode_q;
  scst_baud_type baud_q;
  scst_par_type par_q;
  logic char8_q, two_stop_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_q <= `SCST_RST_MODE;
      baud_q <= `SCST_RST_BAUD;
      char8_q <= `SCST_RST_CHAR8;
      par_q <= `SCST_RST_PAR;
      two_stop_q <= `SCST_RST_TWO_STOP;
    end else if (cfg_wr_i) begin
      // a clear enable keeps the old value
      if (cfg_upd_i[`SCST_UPD_MODE]) mode_q <= cfg_mode_i;
      if (cfg_upd_i[`SCST_UPD_BAUD]) baud_q <= cfg_baud_i;
      if (cfg_upd_i[`SCST_UPD_LONG]) char8_q <= cfg_char8_i;
      if (cfg_upd_i[`SCST_UPD_PAR] && cfg_par_i != 2'd3) par_q <= cfg_par_i;
      if (cfg_upd_i[`SCST_UPD_STOP]) two_stop_q <= cfg_two_stop_i;
    end
  end

  // bit period in clocks; the partner must match this rate
  function automatic logic [19:0] bit_div(input scst_baud_type b);
    case (b)
      SCST_B19200: bit_div = 20'(CLK_HZ / `SCST_BAUD_19200);
      SCST_B4800: bit_div = 20'(CLK_HZ / `SCST_BAUD_4800);
      SCST_B2400: bit_div = 20'(CLK_HZ / `SCST_BAUD_2400);
      SCST_B1200: bit_div = 20'(CLK_HZ / `SCST_BAUD_1200);
      SCST_B600: bit_div = 20'(CLK_HZ / `SCST_BAUD_600);
      SCST_B300: bit_div = 20'(CLK_HZ / `SCST_BAUD_300);
      default: bit_div = 20'(CLK_HZ / `SCST_BAUD_9600);
    endcase
  endfunction

  logic [19:0] div;
  logic [2:0] last_bit;
  logic par_on, par_odd;
  assign div = bit_div(baud_q);
  assign last_bit = char8_q ? 3'h7 : 3'h6;
  assign par_on = (par_q != SCST_PAR_NONE);
  assign par_odd = (par_q == SCST_PAR_ODD);

  // ==========================================
  // role: which lines are driven and which sampled
  logic line_in, rts_in, rx_rdy, partner_ok, paused_q;
  logic tx_line_q;
  assign line_in = role_modem_i ? txd_pin_i : rxd_pin_i;
  assign rts_in = |(rts_pin_i & rts_sel_i);
  assign txd_pin_o = tx_line_q;
  assign rxd_pin_o = tx_line_q;
  assign txd_pin_oe_o = !role_modem_i;
  assign rxd_pin_oe_o = role_modem_i;
  // outside byte handshake the hold-off lines stay asserted
  assign cts_pin_o = (mode_q == SCST_HS_CHAR) ? !rx_rdy : 1'b1;
  assign cts_pin_oe_o = role_modem_i;
  assign dsr_pin_o = 1'b1;
  assign dsr_pin_oe_o = role_modem_i;
  assign dtr_pin_o = 1'b1;
  assign dtr_pin_oe_o = !role_modem_i;
  assign rts_pin_o = {3{(mode_q == SCST_HS_CHAR) ? !rx_rdy : 1'b1}};
  assign rts_pin_oe_o = role_modem_i ? 3'b000 : rts_sel_i;
  assign partner_ok = (mode_q == SCST_HS_FLOW) ? !paused_q :
                      role_modem_i ? (rts_in && dtr_pin_i) : (cts_pin_i && dsr_pin_i);

  // ==========================================
  // transmitter
  scst_state_type tx_st_q;
  logic [19:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_par_q, tx_tick, ctl_pend_q, pause_sent_q;
  logic [7:0] ctl_char_q, tx_word;
  assign tx_tick = (tx_cnt_q == 20'h0);
  assign tx_ready_o = (tx_st_q == SCST_IDLE) && !ctl_pend_q && partner_ok;
  assign tx_word = ctl_pend_q ? ctl_char_q : {1'b0, tx_data_i[6:0]};

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_st_q <= SCST_IDLE;
      tx_line_q <= 1'b1;
      tx_cnt_q <= 20'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h0;
      tx_par_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_tick ? div - 20'h1 : tx_cnt_q - 20'h1;
      case (tx_st_q)
        SCST_IDLE: begin
          tx_line_q <= 1'b1;
          if (ctl_pend_q || (tx_valid_i && tx_ready_o)) begin
            tx_sh_q <= tx_word;
            tx_par_q <= (^tx_word) ^ par_odd;
            tx_line_q <= 1'b0;
            tx_cnt_q <= div - 20'h1;
            tx_bit_q <= 3'h0;
            tx_st_q <= SCST_START;
          end
        end
        SCST_START: begin
          if (tx_tick) begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q <= tx_sh_q >> 1;
            tx_st_q <= SCST_DATA;
          end
        end
        SCST_DATA: begin
          if (tx_tick) begin
            if (tx_bit_q == last_bit) begin
              tx_line_q <= par_on ? tx_par_q : 1'b1;
              tx_st_q <= par_on ? SCST_PARB : SCST_STOP;
              tx_bit_q <= 3'h0;
            end else begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q <= tx_sh_q >> 1;
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        SCST_PARB: begin
          if (tx_tick) begin
            tx_line_q <= 1'b1;
            tx_st_q <= SCST_STOP;
          end
        end
        SCST_STOP: begin
          if (tx_tick) begin
            // a stop setting lowered mid-frame must still end the frame here
            if (tx_bit_q >= {2'b00, two_stop_q}) tx_st_q <= SCST_IDLE;
            else tx_bit_q <= tx_bit_q + 3'h1;
          end
        end
        default: tx_st_q <= SCST_IDLE;
      endcase
    end
  end

  // ==========================================
  // receiver
  scst_state_type rx_st_q;
  logic [19:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_tick, rx_push_q, rx_pbad_q, rx_ctl, fifo_in_ready;
  logic [LW-1:0] level;
  assign rx_tick = (rx_cnt_q == 20'h0);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_st_q <= SCST_IDLE;
      rx_cnt_q <= 20'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h0;
      rx_pbad_q <= 1'b0;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      rx_cnt_q <= rx_tick ? div - 20'h1 : rx_cnt_q - 20'h1;
      case (rx_st_q)
        SCST_IDLE: begin
          if (!line_in) begin
            rx_cnt_q <= (div >> 1) - 20'h1; // sample mid-cell
            rx_sh_q <= 8'h0;
            rx_bit_q <= 3'h0;
            rx_st_q <= SCST_START;
          end
        end
        SCST_START: begin
          if (rx_tick) rx_st_q <= line_in ? SCST_IDLE : SCST_DATA;
        end
        SCST_DATA: begin
          if (rx_tick) begin
            rx_sh_q[rx_bit_q] <= line_in;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) rx_st_q <= par_on ? SCST_PARB : SCST_STOP;
          end
        end
        SCST_PARB: begin
          if (rx_tick) begin
            rx_pbad_q <= ((^rx_sh_q) ^ par_odd) != line_in;
            rx_st_q <= SCST_STOP;
          end
        end
        SCST_STOP: begin
          if (rx_tick) begin
            rx_push_q <= 1'b1;
            rx_st_q <= SCST_IDLE;
          end
        end
        default: rx_st_q <= SCST_IDLE;
      endcase
    end
  end

  // received top bit is discarded in both lengths
  logic [7:0] rx_char;
  assign rx_char = {1'b0, rx_sh_q[6:0]};
  assign rx_ctl = (mode_q == SCST_HS_FLOW) &&
                  (rx_char == `SCST_PAUSE_CHAR || rx_char == `SCST_RESUME_CHAR);

  // ==========================================
  // error flags: a new event wins over the clear
  logic perr_q, ferr_q, oerr_q;
  logic stop_seen;
  assign stop_seen = (rx_st_q == SCST_STOP) && rx_tick;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      perr_q <= (rx_push_q && par_on && rx_pbad_q) || (perr_q && !err_clr_i);
      ferr_q <= (stop_seen && !line_in) || (ferr_q && !err_clr_i);
      oerr_q <= (rx_push_q && !rx_ctl && !fifo_in_ready) || (oerr_q && !err_clr_i);
    end
  end
  assign err_parity_o = perr_q;
  assign err_frame_o = ferr_q;
  assign err_overrun_o = oerr_q;

  // ==========================================
  // receive buffer
  scst_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(rx_push_q && !rx_ctl),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_char),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o),
    .level_o(level)
  );
  assign rx_rdy = rx_valid_o;

  // ==========================================
  // in-band flow control
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || mode_q != SCST_HS_FLOW) begin
      paused_q <= 1'b0;
    end else if (rx_push_q && rx_char == `SCST_PAUSE_CHAR) begin
      paused_q <= 1'b1;
    end else if (rx_push_q && rx_char == `SCST_RESUME_CHAR) begin
      paused_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || mode_q != SCST_HS_FLOW) begin
      ctl_pend_q <= 1'b0;
      ctl_char_q <= `SCST_PAUSE_CHAR;
      pause_sent_q <= 1'b0;
    end else if (ctl_pend_q) begin
      if (tx_st_q == SCST_IDLE) ctl_pend_q <= 1'b0;
    end else if (!pause_sent_q && level >= HI_LVL) begin
      ctl_pend_q <= 1'b1;
      ctl_char_q <= `SCST_PAUSE_CHAR;
      pause_sent_q <= 1'b1;
    end else if (pause_sent_q && level <= LO_LVL) begin
      ctl_pend_q <= 1'b1;
      ctl_char_q <= `SCST_RESUME_CHAR;
      pause_sent_q <= 1'b0;
    end
  end

  // ==========================================
  // checks
  AST_RESET_DEFAULTS: assert property (@(posedge core_clk_i)
    sys_rst_i |=> mode_q == SCST_HS_CHAR && baud_q == SCST_B9600 && char8_q && par_q == SCST_PAR_NONE
      && two_stop_q) else $error("settings not at reset defaults");
  AST_KEEP_BAUD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cfg_wr_i && !cfg_upd_i[`SCST_UPD_BAUD] |=> $stable(baud_q)) else $error("baud changed without enable");
  AST_CTS_INVERSE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mode_q == SCST_HS_CHAR |-> cts_pin_o == (level == '0)) else $error("cts not inverse of ready");
  AST_START_LOW: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_st_q == SCST_IDLE ##1 tx_st_q == SCST_START |-> !tx_line_q) else $error("start bit not low");
  AST_STOP_HIGH: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_st_q == SCST_STOP |-> tx_line_q) else $error("stop bit not high");
  AST_DATA_MSB_ZERO: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rx_valid_o |-> !rx_data_o[7]) else $error("received top bit not zero");
  AST_PAUSE_SENT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mode_q == SCST_HS_FLOW && !ctl_pend_q && !pause_sent_q && level >= HI_LVL ##1 mode_q == SCST_HS_FLOW
      |-> ctl_pend_q && ctl_char_q == `SCST_PAUSE_CHAR) else $error("pause not queued");
  AST_RESUME_SENT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mode_q == SCST_HS_FLOW && !ctl_pend_q && pause_sent_q && level <= LO_LVL ##1 mode_q == SCST_HS_FLOW
      |-> ctl_pend_q && ctl_char_q == `SCST_RESUME_CHAR) else $error("resume not queued");
  AST_FLOW_HOLD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mode_q == SCST_HS_FLOW && paused_q |-> !tx_ready_o) else $error("sent while paused");
  AST_ROLE_LINES: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    role_modem_i |-> rxd_pin_oe_o && !txd_pin_oe_o && rts_pin_oe_o == 3'b000) else $error("modem role drive wrong");
  AST_RTS_ROUTE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !role_modem_i |-> rts_pin_oe_o == rts_sel_i) else $error("rts route wrong");
  AST_PARITY_BIT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_st_q == SCST_DATA && tx_tick && tx_bit_q == last_bit && par_on |=> tx_line_q == tx_par_q)
    else $error("parity bit wrong");
endmodule // scst_serial_channel
`default_nettype wire

// file: verif/scst_partner.sv
// behavioural serial peer standing at the far end of the cable
`timescale 1ns/100ps
`default_nettype none
module scst_partner (
  // clock
  input wire logic core_clk_i,
  // line from and to the channel
  input wire logic line_i,
  output logic line_o,
  // hold-off from the channel and frame setup
  input wire logic go_i,
  input wire logic hs_i,
  input var int div_i,
  input var int nb_i,
  input wire logic [1:0] par_i,
  input var int stops_i
);
  logic [8:0] rx_q[$];
  logic [7:0] sh;
  logic ok;
  int cyc = 0;
  int t_last = 0;
  int gap = 0;
  initial line_o = 1'b1;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  function automatic logic pbit(input logic [7:0] d);
    return (^{d[6:0], d[7] && nb_i == 8}) ^ (par_i == 2'd2);
  endfunction
  // ==========================================
  // receive: mid-cell sampling, flag bad start, parity or stop
  always begin
    @(negedge line_i);
    gap = cyc - t_last;
    t_last = cyc;
    sh = 8'h00;
    repeat (div_i / 2) @(posedge core_clk_i);
    ok = !line_i;
    for (int i = 0; i < nb_i; i++) begin
      repeat (div_i) @(posedge core_clk_i);
      sh[i] = line_i;
    end
    if (par_i != 2'd0) begin
      repeat (div_i) @(posedge core_clk_i);
      ok = ok && (line_i === pbit(sh));
    end
    for (int i = 0; i < stops_i; i++) begin
      repeat (div_i) @(posedge core_clk_i);
      ok = ok && (line_i === 1'b1);
    end
    rx_q.push_back({ok, sh});
  end
  // ==========================================
  // transmit at the channel's own rate; in byte mode wait for clear-to-send
  task automatic send(input logic [7:0] d);
    logic [11:0] fr;
    int n;
    for (n = 0; hs_i && !go_i && n < 20000; n++) @(posedge core_clk_i);
    // a partner held off for good stays idle, so the bench's read runs out
    if (hs_i && !go_i) return;
    fr = 12'hfff;
    for (int i = 0; i < nb_i; i++) fr[i] = d[i];
    if (par_i != 2'd0) fr[nb_i] = pbit(d);
    @(posedge core_clk_i);
    line_o <= 1'b0;
    for (int i = 0; i <= nb_i + (par_i != 2'd0) + stops_i; i++) begin
      repeat (div_i) @(posedge core_clk_i);
      line_o <= fr[i];
    end
  endtask
endmodule // scst_partner
`default_nettype wire

// file: verif/scst_serial_channel_tb.sv
// self-checking bench for the configurable serial channel
`timescale 1ns/100ps
`default_nettype none
module scst_serial_channel_tb;
  import scst_pkg::*;
  localparam int LIM = 20000;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic [4:0] cfg_upd_i = 5'h00;
  scst_hs_type cfg_mode_i = SCST_HS_CHAR;
  scst_baud_type cfg_baud_i = SCST_B9600;
  logic cfg_char8_i = 1'b1;
  scst_par_type cfg_par_i = SCST_PAR_NONE;
  logic cfg_two_stop_i = 1'b1;
  logic role_modem_i = 1'b0;
  logic [2:0] rts_sel_i = 3'h1;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic rx_ready_i = 1'b0;
  logic err_clr_i = 1'b0;
  logic tx_ready_o, rx_valid_o, err_parity_o, err_frame_o, err_overrun_o;
  logic [7:0] rx_data_o;
  logic txd_pin_o, txd_pin_oe_o, rxd_pin_o, rxd_pin_oe_o, cts_pin_o, cts_pin_oe_o;
  logic dsr_pin_o, dsr_pin_oe_o, dtr_pin_o, dtr_pin_oe_o;
  logic [2:0] rts_pin_o, rts_pin_oe_o;
  logic txd_pin_i, rxd_pin_i, to_peer, from_peer, go;
  // peer handshake lines stay asserted
  logic cts_pin_i = 1'b1, dsr_pin_i = 1'b1, dtr_pin_i = 1'b1;
  logic [2:0] rts_pin_i = 3'h7;
  int p_div = 20, p_nb = 8, p_stops = 2;
  logic [1:0] p_par = 2'd0;
  logic p_hs = 1'b1;
  int failures = 0, cmp_count = 0;
  int baud_tab[7] = '{19200, 9600, 4800, 2400, 1200, 600, 300};
  always #2.5 core_clk_i = ~core_clk_i;
  // an undriven data line idles at mark
  assign to_peer = role_modem_i ? (rxd_pin_oe_o ? rxd_pin_o : 1'b1) : (txd_pin_oe_o ? txd_pin_o : 1'b1);
  assign go = role_modem_i ? cts_pin_o : |(rts_pin_o & rts_sel_i);
  assign txd_pin_i = from_peer;
  assign rxd_pin_i = from_peer;
  scst_serial_channel #(.CLK_HZ(192000)) u_scst_serial_channel (
    .core_clk_i, .sys_rst_i, .cfg_wr_i, .cfg_upd_i, .cfg_mode_i, .cfg_baud_i, .cfg_char8_i, .cfg_par_i,
    .cfg_two_stop_i, .role_modem_i, .rts_sel_i, .tx_valid_i, .tx_ready_o, .tx_data_i, .rx_valid_o,
    .rx_ready_i, .rx_data_o, .err_parity_o, .err_frame_o, .err_overrun_o, .err_clr_i, .txd_pin_i,
    .txd_pin_o, .txd_pin_oe_o, .rxd_pin_i, .rxd_pin_o, .rxd_pin_oe_o, .cts_pin_i, .cts_pin_o,
    .cts_pin_oe_o, .dsr_pin_i, .dsr_pin_o, .dsr_pin_oe_o, .dtr_pin_i, .dtr_pin_o, .dtr_pin_oe_o,
    .rts_pin_i, .rts_pin_o, .rts_pin_oe_o);
  scst_partner u_scst_partner (.core_clk_i, .line_i(to_peer), .line_o(from_peer), .go_i(go),
    .hs_i(p_hs), .div_i(p_div), .nb_i(p_nb), .par_i(p_par), .stops_i(p_stops));
  // ==========================================
  // comparison, verdict and bounded waits
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    report_and_stop();
  endtask
  task automatic wait_q(input int n);
    int i;
    for (i = 0; u_scst_partner.rx_q.size() < n && i < LIM; i++) @(posedge core_clk_i);
    if (i == LIM) timeout();
  endtask
  task automatic tx(input logic [7:0] d);
    int i;
    @(negedge core_clk_i);
    tx_valid_i = 1'b1;
    tx_data_i = d;
    for (i = 0; i < LIM; i++) begin
      @(posedge core_clk_i);
      if (tx_ready_o === 1'b1) break;
    end
    @(negedge core_clk_i);
    tx_valid_i = 1'b0;
    if (i == LIM) timeout();
  endtask
  task automatic rd(output logic [7:0] d);
    int i;
    @(negedge core_clk_i);
    for (i = 0; rx_valid_o !== 1'b1 && i < LIM; i++) @(negedge core_clk_i);
    if (i == LIM) timeout();
    else begin
      d = rx_data_o;
      rx_ready_i = 1'b1;
      @(negedge core_clk_i);
      rx_ready_i = 1'b0;
    end
  endtask
  task automatic cfg(input logic [4:0] u, input scst_hs_type m, input scst_baud_type b, input logic c8,
                     input scst_par_type p, input logic two);
    @(negedge core_clk_i);
    cfg_wr_i = 1'b1;
    cfg_upd_i = u;
    cfg_mode_i = m;
    cfg_baud_i = b;
    cfg_char8_i = c8;
    cfg_par_i = p;
    cfg_two_stop_i = two;
    @(negedge core_clk_i);
    cfg_wr_i = 1'b0;
  endtask
  // two frames back to back: content, framing and frame length in clocks
  task automatic tx_pair();
    int f;
    f = 1 + p_nb + (p_par != 2'd0) + p_stops;
    u_scst_partner.rx_q.delete();
    tx(8'ha5);
    tx(8'h5a);
    wait_q(2);
    check(u_scst_partner.rx_q[0], {1'b1, 8'h25});
    check(u_scst_partner.rx_q[1], {1'b1, 8'h5a});
    check(u_scst_partner.gap >= p_div * f && u_scst_partner.gap <= p_div * f + 4, 1'b1);
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] d;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    tx_pair();
    for (int b = 0; b < 7; b++) begin
      @(negedge core_clk_i);
      p_div = 192000 / baud_tab[b];
      p_nb = b[0] ? 8 : 7;
      p_par = 2'(b % 3);
      p_stops = b[1] ? 2 : 1;
      rts_sel_i = 3'h1 << (b % 3);
      cfg(5'h1f, SCST_HS_CHAR, scst_baud_type'(b), b[0], scst_par_type'(b % 3), b[1]);
      check(rts_pin_oe_o, rts_sel_i);
      tx_pair();
      u_scst_partner.send(p_par == 2'd0 ? 8'hc3 : 8'h43);
      repeat (2) @(negedge core_clk_i);
      check(rts_pin_o & rts_sel_i, 3'h0);
      rd(d);
      check(d, 8'h43);
      @(negedge core_clk_i);
      check(rts_pin_o & rts_sel_i, rts_sel_i);
    end
    // only the parity setting changes; 300 baud, 7 bits, 2 stops stay
    cfg(5'h08, SCST_HS_FLOW, SCST_B19200, 1'b1, SCST_PAR_EVEN, 1'b0);
    p_par = 2'd1;
    u_scst_partner.rx_q.delete();
    tx(8'h5a);
    wait_q(1);
    check(u_scst_partner.rx_q[0], {1'b1, 8'h5a});
    @(negedge core_clk_i);
    role_modem_i = 1'b1;
    @(negedge core_clk_i);
    check({txd_pin_oe_o, rxd_pin_oe_o, cts_pin_oe_o, dsr_pin_oe_o, dtr_pin_oe_o, |rts_pin_oe_o}, 6'b011100);
    u_scst_partner.rx_q.delete();
    tx(8'h33);
    wait_q(1);
    check(u_scst_partner.rx_q[0], {1'b1, 8'h33});
    // modem role receive: data comes in on the transmit line, held off by clear-to-send
    check({cts_pin_o, dsr_pin_o, dtr_pin_o}, 3'b111);
    u_scst_partner.send(8'h4e);
    repeat (2) @(negedge core_clk_i);
    check(cts_pin_o, 1'b0);
    rd(d);
    check(d, 8'h4e);
    @(negedge core_clk_i);
    check(cts_pin_o, 1'b1);
    // second reset, then flow control with the far side never stalling
    @(negedge core_clk_i);
    sys_rst_i = 1'b1;
    role_modem_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    p_div = 10;
    p_nb = 8;
    p_par = 2'd0;
    p_stops = 2;
    p_hs = 1'b0;
    cfg(5'h03, SCST_HS_FLOW, SCST_B19200, 1'b1, SCST_PAR_NONE, 1'b1);
    u_scst_partner.rx_q.delete();
    u_scst_partner.send(8'h13);
    repeat (4) @(negedge core_clk_i);
    check(tx_ready_o, 1'b0);
    u_scst_partner.send(8'h11);
    repeat (4) @(negedge core_clk_i);
    check(tx_ready_o, 1'b1);
    for (int i = 0; i < 97; i++) begin
      if (i == 47) begin
        repeat (150) @(negedge core_clk_i);
        check(u_scst_partner.rx_q.size(), 0);
      end
      if (i == 96) check(err_overrun_o, 1'b0);
      u_scst_partner.send(8'h20 + 8'(i));
    end
    repeat (4) @(negedge core_clk_i);
    check(err_overrun_o, 1'b1);
    check({u_scst_partner.rx_q.size() == 1, u_scst_partner.rx_q[0]}, {1'b1, 1'b1, 8'h13});
    check(rts_pin_o & rts_sel_i, rts_sel_i);
    err_clr_i = 1'b1;
    @(negedge core_clk_i);
    err_clr_i = 1'b0;
    @(negedge core_clk_i);
    check(err_overrun_o, 1'b0);
    for (int i = 0; i < 96; i++) begin
      rd(d);
      check(d, 8'h20 + 8'(i));
      if (i == 61) begin
        repeat (150) @(negedge core_clk_i);
        check(u_scst_partner.rx_q.size(), 1);
      end
      if (i == 62) wait_q(2);
    end
    check(u_scst_partner.rx_q[1], {1'b1, 8'h11});
    check(rx_valid_o, 1'b0);
    // wrong parity, then a stop cell that arrives low; both characters are still kept
    cfg(5'h08, SCST_HS_FLOW, SCST_B19200, 1'b1, SCST_PAR_EVEN, 1'b1);
    p_par = 2'd2;
    u_scst_partner.send(8'h41);
    repeat (4) @(negedge core_clk_i);
    check({err_parity_o, err_frame_o}, 2'b10);
    rd(d);
    check(d, 8'h41);
    cfg(5'h0c, SCST_HS_FLOW, SCST_B19200, 1'b0, SCST_PAR_NONE, 1'b1);
    p_par = 2'd0;
    u_scst_partner.send(8'h01);
    repeat (4) @(negedge core_clk_i);
    check(err_frame_o, 1'b1);
    rd(d);
    check(d, 8'h01);
    check(rx_valid_o, 1'b0);
    report_and_stop();
  end
endmodule // scst_serial_channel_tb
`default_nettype wire
